// >>> rtl/port_b_pkg.sv
package port_b_pkg;
  // bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  typedef logic [7:0] byte_type;
  // register byte addresses
  localparam logic [7:0] OFF_PIN_VALUE = 8'h00;
  localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFF_DIRECTION = 8'h08;
  localparam logic [7:0] OFF_ICTL_MAIN = 8'h0c;
  localparam logic [7:0] OFF_ICTL_SECOND = 8'h10;
  localparam logic [7:0] OFF_ICTL_THIRD = 8'h14;
  localparam logic [7:0] OFF_ANALOG_CFG = 8'h18;
  localparam logic [7:0] OFF_ALT_CTRL = 8'h1c;
  // field positions
  localparam int BIT_CHANGE_FLAG = 0;
  localparam int BIT_CHANGE_IRQ_EN = 3;
  localparam int BIT_PULLUP_DIS_N = 7;
  localparam int BIT_CHANGE_PRIO = 0;
  localparam int BIT_CAN_EN = 0;
  localparam int BIT_LVP_EN = 1;
  localparam int PIN_CAN_TX = 2;
  localparam int PIN_CAN_RX = 3;
  localparam int PIN_LVP = 5;
  localparam int CHANGE_LO = 4;
  // implemented-bit masks, others read zero
  localparam byte_type MASK_ICTL_SECOND = 8'hf5;
  localparam byte_type MASK_ICTL_THIRD = 8'hdb;
  localparam byte_type MASK_ANALOG_CFG = 8'h3f;
  localparam byte_type MASK_ALT_CTRL = 8'h03;
  // reset values
  localparam byte_type RST_LATCH = 8'h00;
  localparam byte_type RST_DIRECTION = 8'hff;
  localparam byte_type RST_ICTL_MAIN = 8'h00;
  localparam byte_type RST_ICTL_SECOND = 8'h80;
  localparam byte_type RST_ICTL_THIRD = 8'h00;
  localparam byte_type RST_CFG_ANALOG = 8'h00;
  localparam byte_type RST_CFG_DIGITAL = 8'h0f;
  localparam byte_type RST_ALT_CTRL = 8'h00;
  // analog channel numbers of the pins that carry one
  localparam logic [3:0] CH_PIN0 = 4'ha;
  localparam logic [3:0] CH_PIN1 = 4'h8;
  localparam logic [3:0] CH_PIN4 = 4'h9;
  localparam logic [3:0] CFG_TOP = 4'hf;
endpackage : port_b_pkg

// >>> rtl/pin_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser, output follows once stages two and three agree
module pin_sync (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] async_i,
  output logic [7:0] stable_o
);
  import port_b_pkg::*;

  logic [7:0] stage1;
  logic [7:0] stage2;
  logic [7:0] stage3;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      // stage one feeds only stage two
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          stage1[g] <= 1'b0;
          stage2[g] <= 1'b0;
          stage3[g] <= 1'b0;
          stable_o[g] <= 1'b0;
        end else begin
          stage1[g] <= async_i[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          if (stage2[g] == stage3[g]) begin
            stable_o[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate
endmodule : pin_sync

// >>> rtl/change_detect.sv
`timescale 1ns/10ps
// compares the upper four inputs with the snapshot of the last port access
module change_detect (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] sample_i,
  input wire logic [3:0] input_en_i,
  input wire logic refresh_i,
  input wire logic [3:0] refresh_value_i,
  input wire logic flag_set_i,
  input wire logic flag_clear_i,
  output logic mismatch_o,
  output logic port_change_flag_o
);
  import port_b_pkg::*;

  logic [3:0] snapshot;
  logic port_change_flag;

  // outputs are left out of the comparison
  assign mismatch_o = |((sample_i ^ snapshot) & input_en_i);

  // snapshot refreshed by port access
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      snapshot <= 4'h0;
    end else if (refresh_i) begin
      snapshot <= refresh_value_i;
    end
  end

  // set wins over clear while mismatch stands
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      port_change_flag <= 1'b0;
    end else if (mismatch_o || flag_set_i) begin
      port_change_flag <= 1'b1;
    end else if (flag_clear_i) begin
      port_change_flag <= 1'b0;
    end
  end

  assign port_change_flag_o = port_change_flag;
endmodule : change_detect

// >>> rtl/port_b_gpio.sv
`timescale 1ns/10ps
module port_b_gpio (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [port_b_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [port_b_pkg::DATA_W-1:0] pwdata_i,
  output logic [port_b_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  output logic [7:0] pullup_en_o,
  output logic [7:0] analog_en_o,
  input wire logic analog_at_por_select_i,
  input wire logic can_transmit_out_i,
  input wire logic mem_to_mem_move_i,
  output logic port_change_flag_o,
  output logic wake_o,
  output logic [2:0] ext_irq_in_o,
  output logic can_receive_in_o,
  output logic low_volt_prog_entry_o
);
  import port_b_pkg::*;

  byte_type latch;
  byte_type direction;
  byte_type ictl_main;
  byte_type ictl_second;
  byte_type ictl_third;
  byte_type analog_cfg;
  byte_type alt_ctrl;
  byte_type pin_sync_value;
  byte_type pin_read;
  byte_type analog_mask;
  byte_type alt_own;
  byte_type override_mask;
  byte_type read_value;
  byte_type next_pin;
  byte_type next_oe;
  byte_type next_pullup;
  byte_type wdata;
  logic setup;
  logic access;
  logic wr;
  logic port_access;
  logic can_en;
  logic lvp_en;
  logic mismatch;
  logic change_flag;

  // true for the eight decoded word addresses
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_PIN_VALUE, OFF_OUTPUT_LATCH, OFF_DIRECTION, OFF_ICTL_MAIN,
      OFF_ICTL_SECOND, OFF_ICTL_THIRD, OFF_ANALOG_CFG, OFF_ALT_CTRL: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction : is_mapped

  // channel is analog while its code is at or below the top minus channel
  function automatic logic chan_analog(input logic [3:0] cfg, input logic [3:0] ch);
    chan_analog = (cfg <= (CFG_TOP - ch));
  endfunction : chan_analog

  // apb phases
  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign wr = access & pwrite_i;
  assign wdata = pwdata_i[7:0];
  assign pready_o = 1'b1;
  assign port_access = access & (paddr_i == OFF_PIN_VALUE) & ~mem_to_mem_move_i;

  // alternate function enables
  assign can_en = alt_ctrl[BIT_CAN_EN];
  assign lvp_en = alt_ctrl[BIT_LVP_EN];

  // analog ownership; pins 3..2 follow the channel of pin 1
  always_comb begin
    analog_mask = 8'h00;
    analog_mask[0] = chan_analog(analog_cfg[3:0], CH_PIN0);
    analog_mask[1] = chan_analog(analog_cfg[3:0], CH_PIN1);
    analog_mask[2] = analog_mask[1];
    analog_mask[3] = analog_mask[1];
    analog_mask[4] = chan_analog(analog_cfg[3:0], CH_PIN4);
  end
  assign analog_en_o = analog_mask;

  // pins owned by any alternate function
  always_comb begin
    alt_own = analog_mask;
    alt_own[PIN_CAN_TX] = analog_mask[PIN_CAN_TX] | can_en;
    alt_own[PIN_CAN_RX] = analog_mask[PIN_CAN_RX] | can_en;
    alt_own[PIN_LVP] = lvp_en;
  end

  // pins whose driver is overridden instead of taken from the direction bit
  always_comb begin
    override_mask = 8'h00;
    override_mask[PIN_CAN_TX] = can_en;
    override_mask[PIN_LVP] = lvp_en;
  end

  // pin input synchroniser
  pin_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(pin_i),
    .stable_o(pin_sync_value)
  );

  // analog pins read low on the digital path
  assign pin_read = pin_sync_value & ~analog_mask;

  // synchronised inputs to the peripherals sharing the port
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ext_irq_in_o <= 3'h0;
      can_receive_in_o <= 1'b0;
      low_volt_prog_entry_o <= 1'b0;
    end else begin
      ext_irq_in_o <= pin_read[2:0];
      can_receive_in_o <= pin_sync_value[PIN_CAN_RX];
      low_volt_prog_entry_o <= pin_sync_value[PIN_LVP];
    end
  end

  // output latch: written through the latch or the port address
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      latch <= RST_LATCH;
    end else if (wr && (paddr_i == OFF_OUTPUT_LATCH || paddr_i == OFF_PIN_VALUE)) begin
      latch <= wdata;
    end
  end

  // direction register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      direction <= RST_DIRECTION;
    end else if (wr && paddr_i == OFF_DIRECTION) begin
      direction <= wdata;
    end
  end

  // main control, flag bit lives in the change detector
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ictl_main <= RST_ICTL_MAIN;
    end else if (wr && paddr_i == OFF_ICTL_MAIN) begin
      ictl_main <= wdata;
    end
  end

  // second and third controls
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ictl_second <= RST_ICTL_SECOND;
      ictl_third <= RST_ICTL_THIRD;
    end else if (wr && paddr_i == OFF_ICTL_SECOND) begin
      ictl_second <= wdata & MASK_ICTL_SECOND;
    end else if (wr && paddr_i == OFF_ICTL_THIRD) begin
      ictl_third <= wdata & MASK_ICTL_THIRD;
    end
  end

  // analog configuration, reset value picked by the strap
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      analog_cfg <= analog_at_por_select_i ? RST_CFG_DIGITAL : RST_CFG_ANALOG;
    end else if (wr && paddr_i == OFF_ANALOG_CFG) begin
      analog_cfg <= wdata & MASK_ANALOG_CFG;
    end
  end

  // alternate function enables
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      alt_ctrl <= RST_ALT_CTRL;
    end else if (wr && paddr_i == OFF_ALT_CTRL) begin
      alt_ctrl <= wdata & MASK_ALT_CTRL;
    end
  end

  // read multiplexer
  always_comb begin
    case (paddr_i)
      OFF_PIN_VALUE: read_value = pin_read;
      OFF_OUTPUT_LATCH: read_value = latch;
      OFF_DIRECTION: read_value = direction;
      OFF_ICTL_MAIN: read_value = {ictl_main[7:1], change_flag};
      OFF_ICTL_SECOND: read_value = ictl_second;
      OFF_ICTL_THIRD: read_value = ictl_third;
      OFF_ANALOG_CFG: read_value = analog_cfg;
      OFF_ALT_CTRL: read_value = alt_ctrl;
      default: read_value = 8'h00;
    endcase
  end

  // read data and error taken at setup, shown through the access phase
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o <= {24'h0, read_value};
      pslverr_o <= ~is_mapped(paddr_i);
    end
  end

  // change detection on the upper four pins
  change_detect u_change (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .sample_i(pin_read[7:CHANGE_LO]),
    .input_en_i(direction[7:CHANGE_LO]),
    .refresh_i(port_access),
    .refresh_value_i(pwrite_i ? pin_read[7:CHANGE_LO] : prdata_o[7:CHANGE_LO]),
    .flag_set_i(wr && paddr_i == OFF_ICTL_MAIN && wdata[BIT_CHANGE_FLAG]),
    .flag_clear_i(wr && paddr_i == OFF_ICTL_MAIN && !wdata[BIT_CHANGE_FLAG]),
    .mismatch_o(mismatch),
    .port_change_flag_o(change_flag)
  );
  assign port_change_flag_o = change_flag;

  // wake request while the change event is enabled
  assign wake_o = change_flag & ictl_main[BIT_CHANGE_IRQ_EN];

  // pin drive with alternate overrides
  always_comb begin
    next_oe = ~direction;
    next_pin = latch;
    if (can_en) begin
      next_oe[PIN_CAN_TX] = 1'b1;
      next_pin[PIN_CAN_TX] = can_transmit_out_i;
    end
    if (lvp_en) begin
      next_oe[PIN_LVP] = 1'b0;
    end
  end

  // pull-ups only on plain digital inputs with the global enable low
  always_comb begin
    if (ictl_second[BIT_PULLUP_DIS_N]) begin
      next_pullup = 8'h00;
    end else begin
      next_pullup = direction & ~alt_own;
    end
  end

  // registered pin outputs
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
      pullup_en_o <= 8'h00;
    end else begin
      pin_o <= next_pin;
      pin_oe_o <= next_oe;
      pullup_en_o <= next_pullup;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  a_dir_hiz_drive: assert property (
    1'b1 |=> ((pin_oe_o & ~$past(override_mask)) == (~$past(direction) & ~$past(override_mask))))
    else $error("pin enable does not follow direction");

  a_latch_read_back: assert property (
    (access && !pwrite_i && paddr_i == OFF_OUTPUT_LATCH) |-> (prdata_o[7:0] == latch))
    else $error("latch read returned wrong value");

  a_pullup_global_on: assert property (
    (wr && paddr_i == OFF_ICTL_SECOND && !wdata[BIT_PULLUP_DIS_N]) ##1 1'b1
    |=> (pullup_en_o == ($past(direction) & ~$past(alt_own))))
    else $error("pull-ups not enabled by global bit");

  a_pullup_not_output: assert property (
    1'b1 |=> ((pullup_en_o & ~$past(direction)) == 8'h00))
    else $error("pull-up on an output pin");

  a_reset_pullups_off: assert property (
    $past(reset_i) |-> (pullup_en_o == 8'h00 && ictl_second[BIT_PULLUP_DIS_N]))
    else $error("pull-ups enabled after reset");

  a_por_analog_mask: assert property (
    $past(reset_i) |-> (analog_mask == ($past(analog_at_por_select_i) ? 8'h00 : 8'h1f)))
    else $error("analog state after reset wrong");

  a_outputs_excluded: assert property (
    (direction[7:CHANGE_LO] == 4'h0) |-> !mismatch)
    else $error("output pin raised a mismatch");

  a_mismatch_sets_flag: assert property (
    mismatch |=> change_flag)
    else $error("mismatch did not set change flag");

  a_wake_from_change: assert property (
    (mismatch && ictl_main[BIT_CHANGE_IRQ_EN]) |=> wake_o)
    else $error("no wake on enabled change");

  a_analog_reads_low: assert property (
    (setup && !pwrite_i && paddr_i == OFF_PIN_VALUE)
    |=> ((prdata_o[7:0] & $past(analog_mask)) == 8'h00))
    else $error("analog pin read high");

  a_can_tx_drive: assert property (
    can_en |=> (pin_oe_o[PIN_CAN_TX] && pin_o[PIN_CAN_TX] == $past(can_transmit_out_i)))
    else $error("can transmit not on pin");

  a_lvp_release: assert property (
    lvp_en |=> !pin_oe_o[PIN_LVP])
    else $error("programming pin driven");

  a_port_write_latch: assert property (
    (wr && paddr_i == OFF_PIN_VALUE) |=> (latch == $past(wdata)))
    else $error("port write did not load latch");

  c_change_flag_rise: cover property (!change_flag ##1 change_flag);
  c_read_then_clear: cover property (port_access && !pwrite_i ##[1:4] !change_flag);
  c_can_enabled: cover property (can_en && !direction[PIN_CAN_TX]);
  c_wake_raised: cover property (!wake_o ##1 wake_o);
endmodule : port_b_gpio

// >>> bench/pin_board.sv
`timescale 1ns/10ps
// board side of the port: keypads and other external sources on each pin
module pin_board (
  input wire logic ref_clk_i,
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] pin_oe_i,
  input wire logic [7:0] pullup_en_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [7:0] ext_drive_i,
  output logic [7:0] level_o
);
  logic [7:0] drift = 8'h55;
  // a floating pin shows a changing pattern, never a held value
  always @(posedge ref_clk_i) begin
    drift <= ~drift;
  end
  // device driver wins, then the external source, then the weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) level_o[i] = pin_o_i[i];
      else if (ext_drive_i[i]) level_o[i] = ext_val_i[i];
      else if (pullup_en_i[i]) level_o[i] = 1'b1;
      else level_o[i] = drift[i];
    end
  end
endmodule : pin_board

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import port_b_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic pready, pslverr, err, flag, wake, can_rx, lvp_in;
  logic [7:0] pin_o, pin_oe, pullup_en, analog_en, level;
  logic [2:0] ext_irq;
  logic strap = 1'b0;
  logic can_tx = 1'b0;
  logic m2m = 1'b0;
  logic [7:0] ext_val = 8'hff;
  logic [7:0] ext_drive = 8'hff;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed_val;
  byte_type lat, dir, lv;
  localparam byte_type RST_V [7] = '{RST_LATCH, RST_DIRECTION, RST_ICTL_MAIN,
    RST_ICTL_SECOND, RST_ICTL_THIRD, RST_CFG_ANALOG, RST_ALT_CTRL};

  port_b_gpio port_b_gpio_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pin_i(level),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .pullup_en_o(pullup_en), .analog_en_o(analog_en),
    .analog_at_por_select_i(strap), .can_transmit_out_i(can_tx),
    .mem_to_mem_move_i(m2m), .port_change_flag_o(flag), .wake_o(wake),
    .ext_irq_in_o(ext_irq), .can_receive_in_o(can_rx), .low_volt_prog_entry_o(lvp_in));

  pin_board pin_board_i (.ref_clk_i(ref_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe),
    .pullup_en_i(pullup_en), .ext_val_i(ext_val), .ext_drive_i(ext_drive),
    .level_o(level));

  // 25 MHz clock
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_n

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] addr, input byte_type data);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    paddr <= addr;
    pwrite <= wr;
    pwdata <= {24'h0, data};
    @(posedge ref_clk_i);
    penable <= 1'b1;
    @(posedge ref_clk_i);
    while (pready !== 1'b1) @(posedge ref_clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] addr, input byte_type exp, input string name);
    apb(1'b0, addr, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask : rdchk

  task automatic do_reset;
    reset_i <= 1'b1;
    wait_n(20);
    reset_i <= 1'b0;
    wait_n(2);
  endtask : do_reset

  // pin level seen at the port: driven pins show the latch, inputs the board
  function automatic byte_type lvl(byte_type l, byte_type d, byte_type e);
    return (l & ~d) | (e & d);
  endfunction : lvl

  initial begin
    seed_val = $urandom(32'ha142);
    // reset values, analog pins, unmapped address, first change event
    do_reset();
    // main control already shows the flag raised from the zero snapshot
    for (int k = 0; k < 7; k++) begin
      rdchk(8'(4 * k + 4), RST_V[k] | byte_type'(k == 2), "reset value");
    end
    chk("pullups at reset", 0, pullup_en);
    chk("analog at reset", 8'h1f, analog_en);
    rdchk(OFF_PIN_VALUE, 8'he0, "analog pins read low");
    chk("analog irq pins low", 0, ext_irq);
    chk("flag from reset snapshot", 1, flag);
    apb(1'b1, OFF_ICTL_MAIN, 8'h00);
    wait_n(2);
    chk("flag cleared after read", 0, flag);
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    chk("ready", 1, pready);
    $display("test reset done");
    // random latch and direction, pull-ups on
    apb(1'b1, OFF_ANALOG_CFG, 8'h0f);
    apb(1'b1, OFF_ICTL_SECOND, 8'h00);
    for (int k = 0; k < 5; k++) begin
      lat = byte_type'($urandom);
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : byte_type'($urandom);
      ext_val <= byte_type'($urandom);
      apb(1'b1, OFF_OUTPUT_LATCH, lat);
      apb(1'b1, OFF_DIRECTION, dir);
      wait_n(8);
      chk("pin drive", byte_type'(~dir), pin_oe);
      chk("pin out", lat & byte_type'(~dir), pin_o & byte_type'(~dir));
      chk("pullups", dir, pullup_en);
      rdchk(OFF_OUTPUT_LATCH, lat, "latch read");
      rdchk(OFF_PIN_VALUE, lvl(lat, dir, ext_val), "pin read");
      lv = lvl(lat, dir, ext_val);
      chk("peripheral pins", {lv[5], lv[3], lv[2:0]}, {lvp_in, can_rx, ext_irq});
    end
    apb(1'b1, OFF_PIN_VALUE, 8'h3c);
    rdchk(OFF_OUTPUT_LATCH, 8'h3c, "port write to latch");
    $display("test port done");
    // change detection: port read once for the snapshot, then only after an event, no polling
    apb(1'b1, OFF_DIRECTION, 8'hff);
    ext_val <= 8'ha5;
    wait_n(8);
    apb(1'b0, OFF_PIN_VALUE, 8'h00);
    apb(1'b1, OFF_ICTL_MAIN, 8'h08);
    wait_n(8);
    chk("flag idle", 0, flag);
    ext_val <= 8'he5;
    wait_n(8);
    chk("flag set", 1, flag);
    chk("wake", 1, wake);
    apb(1'b1, OFF_ICTL_MAIN, 8'h08);
    wait_n(2);
    chk("flag held", 1, flag);
    m2m <= 1'b1;
    apb(1'b0, OFF_PIN_VALUE, 8'h00);
    m2m <= 1'b0;
    apb(1'b1, OFF_ICTL_MAIN, 8'h08);
    wait_n(2);
    chk("flag after move", 1, flag);
    apb(1'b0, OFF_PIN_VALUE, 8'h00);
    apb(1'b1, OFF_ICTL_MAIN, 8'h08);
    wait_n(2);
    chk("flag cleared", 0, flag);
    chk("wake off", 0, wake);
    ext_val <= 8'he4;
    apb(1'b1, OFF_DIRECTION, 8'h7f);
    wait_n(8);
    chk("excluded pins", 0, flag);
    $display("test change done");
    // alternate functions own their pins
    apb(1'b1, OFF_DIRECTION, 8'hfb);
    apb(1'b1, OFF_ALT_CTRL, 8'h01);
    for (int k = 0; k < 4; k++) begin
      can_tx <= k[0];
      wait_n(3);
      chk("can drive", 1, pin_oe[PIN_CAN_TX]);
      chk("can bit", k[0], pin_o[PIN_CAN_TX]);
    end
    chk("can pins no pullup", 8'hf3, pullup_en);
    apb(1'b1, OFF_ALT_CTRL, 8'h02);
    apb(1'b1, OFF_DIRECTION, 8'h00);
    wait_n(3);
    chk("entry pin driver off", 8'hdf, pin_oe);
    chk("outputs no pullup", 0, pullup_en);
    $display("test alternate done");
    // strap selects digital pins at reset
    strap <= 1'b1;
    do_reset();
    rdchk(OFF_ANALOG_CFG, RST_CFG_DIGITAL, "strap digital");
    chk("strap no analog", 0, analog_en);
    chk("pullups second reset", 0, pullup_en);
    // partial analog setting: pins 4..1 analog, pin 0 digital
    ext_val <= 8'he5;
    apb(1'b1, OFF_ANALOG_CFG, 8'h06);
    wait_n(1);
    chk("partial analog", 8'h1e, analog_en);
    rdchk(OFF_PIN_VALUE, 8'he1, "partial analog read");
    $display("test strap done");
    end_sim();
  end
endmodule : tb_top
